// File: core/clock_mode_control.sv
`timescale 1ns/100ps
module clock_mode_control
    import clock_mode_pkg::*;
#(
    parameter logic [LOCK_W-1:0] LOCK_COUNT = LOCK_W'(LOCK_CYCLES)
) (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // Register port
    input  wire logic [3:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [15:0] rdata,
    // Strap pins
    input  wire logic        bypass_pin,
    input  wire logic        input_divide_pin,
    // Shared select and flag pins
    input  wire logic [6:0]  general_flag_pin_i,
    output logic      [6:0]  general_flag_pin_o,
    output logic      [6:0]  general_flag_pin_oe,
    // Flag unit side
    input  wire logic [6:0]  flag_out_data,
    input  wire logic [6:0]  flag_out_oe,
    output logic      [6:0]  flag_in_data,
    // Wake sources
    input  wire logic        flag_wake_event,
    input  wire logic        timer_wake_event_a,
    input  wire logic        timer_wake_event_b,
    input  wire logic        timer_wake_event_c,
    input  wire logic        irq_wake,
    // Clock outputs
    output logic             core_clock_en,
    output logic             peripheral_clock_en,
    output logic             clock_out_en,
    output logic             core_from_loop,
    output logic             loop_power_on,
    output logic      [6:0]  core_ratio,
    output logic      [7:0]  loop_ratio,
    output logic      [4:0]  mode_state
);

    // ==========================================================
    // Synchronisers
    logic [8:0]  strap_s1;
    logic [8:0]  strap_s2;
    logic [3:0]  wake_s1;
    logic [3:0]  wake_s2;

    // No reset here: straps must be sampled while reset is held
    always_ff @(posedge ref_clk) begin
        strap_s1 <= {bypass_pin, input_divide_pin, general_flag_pin_i};
        strap_s2 <= strap_s1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wake_s1 <= 4'h0;
            wake_s2 <= 4'h0;
        end else begin
            wake_s1 <= {timer_wake_event_c, timer_wake_event_b,
                        timer_wake_event_a, flag_wake_event};
            wake_s2 <= wake_s1;
        end
    end

    // ==========================================================
    // State
    clock_mode_e mode;
    clock_mode_e next_mode;
    logic [15:0] ctrl;
    logic [15:0] wmask;
    logic [15:0] next_ctrl;
    logic        ctrl_wr;
    logic        mult_change;
    logic        any_wake;
    logic        idle_wake;
    logic        loop_req_on;
    logic        lock_restart;
    logic        lock_done;
    logic [LOCK_W-1:0] lock_left;
    logic        flags_live;
    logic        half_phase;
    logic        periph_phase;
    logic        rd_q;

    assign ctrl_wr     = wr && (addr == CTRL_OFS);
    assign any_wake    = |wake_s2;
    assign idle_wake   = any_wake || (irq_wake && !ctrl[BIT_ALLHALT]);
    assign loop_req_on = !ctrl[BIT_PWRDOWN] && !ctrl[BIT_LOOPOFF];

    // ==========================================================
    // Write masking per mode
    always_comb begin
        case (mode)
            mode_mult:    wmask = WMASK_MULT;
            mode_bypass:  wmask = ctrl[BIT_BYPASS] ?
                                  (WMASK_BYPASS | WMASK_BYP_HI) :
                                  WMASK_BYPASS;
            mode_pd_loop: wmask = WMASK_PDLOOP;
            default:      wmask = 16'h0000;
        endcase
    end

    assign next_ctrl = (ctrl & ~wmask) | (wdata & wmask);

    // ==========================================================
    // Control register
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            // Loaded every reset cycle; last value is held at release
            ctrl <= 16'h0000;
            ctrl[BIT_BYPASS] <= strap_s2[8];
            ctrl[BIT_DIVIDE] <= strap_s2[7];
            ctrl[SEL_MSB:SEL_LSB] <= strap_s2[8] ? SEL_STRAP_BYPASS
                                                 : strap_s2[6:0];
        end else if (idle_wake && (mode == mode_idle)) begin
            ctrl[BIT_CORHALT] <= 1'b0;
            ctrl[BIT_ALLHALT] <= 1'b0;
        end else if (any_wake && (mode == mode_pd_all)) begin
            ctrl[BIT_CORHALT] <= 1'b0;
            ctrl[BIT_ALLHALT] <= 1'b0;
        end else if (ctrl_wr) begin
            ctrl <= next_ctrl;
        end
    end

    // A changed half or ratio bit in multiplier mode relocks via bypass
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mult_change <= 1'b0;
        end else begin
            mult_change <= ctrl_wr && (mode == mode_mult) &&
                           (next_ctrl != ctrl);
        end
    end

    // ==========================================================
    // Mode arbitration
    always_comb begin
        next_mode = mode;
        case (mode)
            mode_mult: begin
                if (ctrl[BIT_CORHALT] || ctrl[BIT_ALLHALT]) begin
                    next_mode = mode_idle;
                end else if (ctrl[BIT_PWRDOWN]) begin
                    next_mode = mode_pd_loop;
                end else if (ctrl[BIT_BYPASS] || mult_change) begin
                    next_mode = mode_bypass;
                end
            end
            mode_bypass: begin
                if (ctrl[BIT_PWRDOWN] && ctrl[BIT_LOOPOFF]) begin
                    next_mode = mode_pd_all;
                end else if (ctrl[BIT_CORHALT] || ctrl[BIT_ALLHALT]) begin
                    next_mode = mode_idle;
                end else if (!loop_req_on) begin
                    next_mode = mode_pd_loop;
                end else if (!ctrl[BIT_BYPASS] && lock_done) begin
                    next_mode = mode_mult;
                end
            end
            mode_pd_loop: begin
                if (ctrl[BIT_CORHALT] || ctrl[BIT_ALLHALT]) begin
                    next_mode = mode_pd_all;
                end else if (loop_req_on) begin
                    next_mode = mode_bypass;
                end
            end
            mode_idle: begin
                if (idle_wake) begin
                    next_mode = (ctrl[BIT_BYPASS] || !lock_done) ?
                                mode_bypass : mode_mult;
                end
            end
            mode_pd_all: begin
                if (any_wake) begin
                    next_mode = ctrl[BIT_LOOPOFF] ? mode_bypass
                                                  : mode_pd_loop;
                end
            end
            default: next_mode = mode_bypass;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mode <= mode_bypass;
        end else begin
            mode <= next_mode;
        end
    end

    // ==========================================================
    // Lock counter
    assign lock_restart = ((mode != mode_bypass) &&
                           (next_mode == mode_bypass) &&
                           (mode != mode_idle)) ||
                          (ctrl_wr && (mode == mode_bypass) &&
                           ((next_ctrl ^ ctrl) & WMASK_BYP_HI) != 16'h0000);

    lock_counter #(
        .LOCK_COUNT (LOCK_COUNT)
    ) u_lock (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .restart (lock_restart),
        .run     (loop_req_on && (mode != mode_pd_all)),
        .done    (lock_done),
        .left    (lock_left)
    );

    // ==========================================================
    // Ratio outputs
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            core_ratio <= 7'h02;
            loop_ratio <= 8'h02;
        end else if ((mode == mode_bypass) || (mode == mode_pd_loop)) begin
            core_ratio <= core_ratio_x2(ctrl[SEL_MSB:SEL_LSB],
                                        ctrl[BIT_DIVIDE]);
            loop_ratio <= loop_ratio_x2(ctrl[SEL_MSB:SEL_LSB],
                                        ctrl[BIT_DIVIDE]);
        end
    end

    // ==========================================================
    // Clock enables
    logic core_run;
    logic periph_run;
    logic core_tick;

    assign core_run   = (mode == mode_mult) || (mode == mode_bypass) ||
                        (mode == mode_pd_loop);
    assign periph_run = core_run ||
                        ((mode == mode_idle) && !ctrl[BIT_ALLHALT]);
    // Bypass half divide thins the reference-rate enable
    assign core_tick  = !ctrl[BIT_HALF] || (mode == mode_mult) || half_phase;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            half_phase <= 1'b0;
        end else begin
            half_phase <= !half_phase;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            periph_phase <= 1'b0;
        end else if (core_tick) begin
            periph_phase <= !periph_phase;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            core_clock_en       <= 1'b0;
            peripheral_clock_en <= 1'b0;
            clock_out_en        <= 1'b0;
        end else begin
            core_clock_en       <= core_run && core_tick;
            peripheral_clock_en <= periph_run && core_tick &&
                                   (!ctrl[BIT_RATIO] || periph_phase);
            clock_out_en        <= ctrl[BIT_CLKOUT] && periph_run &&
                                   core_tick &&
                                   (!ctrl[BIT_RATIO] || periph_phase);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            core_from_loop <= 1'b0;
            loop_power_on  <= 1'b0;
            mode_state     <= mode_bypass;
        end else begin
            core_from_loop <= (mode == mode_mult);
            loop_power_on  <= loop_req_on && (mode != mode_pd_all) &&
                              (mode != mode_pd_loop);
            mode_state     <= mode;
        end
    end

    // ==========================================================
    // Shared flag pins
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flags_live          <= 1'b0;
            general_flag_pin_o  <= 7'h00;
            general_flag_pin_oe <= 7'h00;
            flag_in_data        <= 7'h00;
        end else begin
            flags_live          <= 1'b1;
            general_flag_pin_o  <= flags_live ? flag_out_data : 7'h00;
            general_flag_pin_oe <= flags_live ? flag_out_oe : 7'h00;
            flag_in_data        <= flags_live ? strap_s2[6:0] : 7'h00;
        end
    end

    // ==========================================================
    // Read port
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_q  <= 1'b0;
            rdata <= 16'h0000;
        end else begin
            rd_q <= rd;
            if (rd && (addr == CTRL_OFS)) begin
                rdata <= ctrl;
            end else if (rd && (addr == STATUS_OFS)) begin
                rdata <= {lock_done, mode, lock_left};
            end else begin
                rdata <= 16'h0000;
            end
        end
    end

    // ==========================================================
    // Checks
    a_reset_bypass: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> mode == mode_bypass)
        else $error("mode not bypass after reset");

    a_pd_all_prio: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode == mode_bypass) && ctrl[BIT_PWRDOWN] && ctrl[BIT_LOOPOFF]
        |=> mode == mode_pd_all)
        else $error("power-down-all not taken first");

    a_pd_all_dark: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode == mode_pd_all) ##1 (mode == mode_pd_all)
        |-> !core_clock_en && !peripheral_clock_en)
        else $error("clock running in power-down-all");

    a_pd_all_frozen: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode == mode_pd_all) && !any_wake |=> $stable(ctrl))
        else $error("control changed in power-down-all");

    a_mult_mask: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode == mode_mult) && ctrl_wr
        |=> ctrl[15:9] == $past(ctrl[15:9]) && ctrl[1:0] == $past(ctrl[1:0]))
        else $error("locked bit written in multiplier mode");

    a_lock_to_mult: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode == mode_bypass) && lock_done && (ctrl[8:2] & 7'h4b) == 7'h00
        && !ctrl[BIT_LOOPOFF] |=> mode == mode_mult ##1 core_from_loop)
        else $error("no switch to loop after lock");

    a_flags_quiet: assert property (@(posedge ref_clk)
        $rose(rst_n) |-> general_flag_pin_oe == 7'h00 && flag_in_data == 7'h00)
        else $error("flag pins active in reset");

    a_ratio_six: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (mode == mode_bypass) && ctrl[15:9] == 7'h06 && !ctrl[BIT_DIVIDE]
        |=> core_ratio == 7'h0c)
        else $error("ratio for select six wrong");

    a_read_slot: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !rd_q |-> rdata == 16'h0000)
        else $error("read data outside its cycle");

endmodule

// File: core/clock_mode_pkg.sv
// Notes on behaviour
// - Select bits 4:0 valued N give N times reference; zero gives 32 times.
// - Select bit 5 set needs divide set; ratios equal bit5 clear, divide clear.
// - Shared pins act as selects during reset, as flag pins afterwards.
// - Flag input and output on shared pins stop while reset is asserted.
// - Select, bypass and divide levels are captured at reset release.
// - With bypass strapped, select pin levels are ignored.
// - Runtime ratio comes from control select bits only in bypass or loop-down.
// - Control bits drive mode changes, resolved by fixed priorities.
// - Bypass plus power-down and loop-off together enters power-down-all.
// - Power-down-all stops every clock; only the four wake events leave it.
// - Idle stops core clock, maybe peripheral; wake event, or interrupt unless all-halt set, leaves.
// - Multiplier mode only accepts halt, bypass, power-down, half, ratio bits.
// - Any change of a writable bit in multiplier mode forces a transition.
// - Bypass runs clocks from reference; lock counter gates return to multiplier.
// - Bypass writes most bits; half, select, divide only while bypass is one.
// - Control layout: divide 0, off 1, all 2, core 3, ratio 4 ... select 15:9.
// - After reset the unit starts in bypass, core clock from reference.
// - Peripheral clock equals core clock, or half of it with ratio bit set.
// - Leaving bypass waits for lock expiry, then switches to the loop.
package clock_mode_pkg;

    // ==========================================================
    // Register map
    localparam logic [3:0]  CTRL_OFS   = 4'h0;
    localparam logic [3:0]  STATUS_OFS = 4'h1;

    localparam int          BIT_DIVIDE  = 0;
    localparam int          BIT_LOOPOFF = 1;
    localparam int          BIT_ALLHALT = 2;
    localparam int          BIT_CORHALT = 3;
    localparam int          BIT_RATIO   = 4;
    localparam int          BIT_PWRDOWN = 5;
    localparam int          BIT_CLKOUT  = 6;
    localparam int          BIT_HALF    = 7;
    localparam int          BIT_BYPASS  = 8;
    localparam int          SEL_LSB     = 9;
    localparam int          SEL_MSB     = 15;

    // Select value used when bypass is strapped and pins are ignored
    localparam logic [6:0]  SEL_STRAP_BYPASS = 7'h01;

    // Writable masks per mode
    localparam logic [15:0] WMASK_MULT   = 16'h01bc;
    localparam logic [15:0] WMASK_BYPASS = 16'h017e;
    localparam logic [15:0] WMASK_BYP_HI = 16'hfe81;
    localparam logic [15:0] WMASK_PDLOOP = 16'hfefe;

    // Loop lock time in reference cycles
    localparam int          LOCK_W      = 10;
    localparam int          LOCK_CYCLES = 500;

    // ==========================================================
    // Modes
    typedef enum logic [4:0] {
        mode_mult    = 5'b00001,
        mode_bypass  = 5'b00010,
        mode_pd_loop = 5'b00100,
        mode_idle    = 5'b01000,
        mode_pd_all  = 5'b10000
    } clock_mode_e;

    // Core ratio in half steps
    function automatic logic [6:0] core_ratio_x2(input logic [6:0] sel,
                                                 input logic       div);
        logic [6:0] base;
        logic [1:0] sh;
        base = (sel[4:0] == 5'h00) ? 7'h40 : {1'b0, sel[4:0], 1'b0};
        // Bit 5 set with divide set behaves as both clear
        sh   = sel[5] ? {1'b0, sel[6]} : 2'({1'b0, sel[6]} + {1'b0, div});
        core_ratio_x2 = base >> sh;
    endfunction

    function automatic logic [7:0] loop_ratio_x2(input logic [6:0] sel,
                                                 input logic       div);
        loop_ratio_x2 = {1'b0, core_ratio_x2(sel, div)} << sel[6];
    endfunction

endpackage

// File: core/lock_counter.sv
`timescale 1ns/100ps
module lock_counter
    import clock_mode_pkg::*;
#(
    parameter logic [LOCK_W-1:0] LOCK_COUNT = LOCK_W'(LOCK_CYCLES)
) (
    // Clock and reset
    input  wire logic              ref_clk,
    input  wire logic              rst_n,
    // Control
    input  wire logic              restart,
    input  wire logic              run,
    // Result
    output logic                   done,
    output logic [LOCK_W-1:0]      left
);

    // ==========================================================
    // Countdown
    always_ff @(posedge ref_clk) begin
        if (!rst_n || restart || !run) begin
            left <= LOCK_COUNT;
        end else if (left != '0) begin
            left <= left - LOCK_W'(1);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n || restart || !run) begin
            done <= 1'b0;
        end else begin
            done <= (left == LOCK_W'(1)) || (left == '0);
        end
    end

endmodule

// File: sim/strap_source.sv
`timescale 1ns/100ps
module strap_source (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Strap resistor setting
    input  wire logic [6:0] cfg_sel,
    input  wire logic       cfg_bypass,
    input  wire logic       cfg_divide,
    // Device drive on the shared pins
    input  wire logic [6:0] pin_o,
    input  wire logic [6:0] pin_oe,
    // Levels seen by the device
    output logic            bypass_pin,
    output logic            input_divide_pin,
    output logic      [6:0] general_flag_pin_i
);
    // ==========================================================
    // Hold window after release
    logic [1:0] hold;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hold <= 2'h3;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end
    end

    // Resistor straps never move, so release timing is met
    assign bypass_pin       = cfg_bypass;
    // Select bit 5 forces divide high
    assign input_divide_pin = cfg_divide | cfg_sel[5];
    // Pull resistors win wherever the device is not driving
    assign general_flag_pin_i = (!rst_n || hold != 2'h0) ? cfg_sel :
        ((pin_oe & pin_o) | (~pin_oe & cfg_sel));
    // Strapped ratios keep a 25 MHz loop in 10..800 MHz
endmodule

// File: sim/test_clock_mode_control.sv
`timescale 1ns/100ps
module test_clock_mode_control import clock_mode_pkg::*;;
    // ==========================================================
    // Signals
    logic        ref_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [15:0] rdata;
    logic        bypass_pin;
    logic        input_divide_pin;
    logic [6:0]  pin_i;
    logic [6:0]  pin_o;
    logic [6:0]  pin_oe;
    logic [6:0]  flag_out_data = 7'h00;
    logic [6:0]  flag_out_oe = 7'h00;
    logic [6:0]  flag_in_data;
    logic        wake_f = 1'b0;
    logic        wake_a = 1'b0;
    logic        wake_b = 1'b0;
    logic        wake_c = 1'b0;
    logic        irq_wake = 1'b0;
    logic        core_clock_en;
    logic        peripheral_clock_en;
    logic        clock_out_en;
    logic        loop_power_on;
    logic        core_from_loop;
    logic [6:0]  core_ratio;
    logic [7:0]  loop_ratio;
    logic [4:0]  mode_state;
    logic [6:0]  cfg_sel = 7'h06;
    logic        cfg_bypass = 1'b1;
    logic        cfg_divide = 1'b0;
    logic [15:0] val;
    logic [3:0]  n_core;
    logic [3:0]  n_per;
    logic [3:0]  n_out;
    int          err_total = 0;
    int          n_compared = 0;
    logic [6:0]  t_sel [5] = '{7'h00, 7'h06, 7'h06, 7'h46, 7'h26};
    logic        t_div [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    logic [7:0]  t_core [5] = '{8'h40, 8'h0c, 8'h06, 8'h06, 8'h0c};
    logic [7:0]  t_loop [5] = '{8'h40, 8'h0c, 8'h06, 8'h0c, 8'h0c};

    always #20 ref_clk = ~ref_clk;

    clock_mode_control #(.LOCK_COUNT(LOCK_W'(8))) clock_mode_control_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .bypass_pin(bypass_pin),
        .input_divide_pin(input_divide_pin), .general_flag_pin_i(pin_i),
        .general_flag_pin_o(pin_o), .general_flag_pin_oe(pin_oe),
        .flag_out_data(flag_out_data), .flag_out_oe(flag_out_oe),
        .flag_in_data(flag_in_data), .flag_wake_event(wake_f),
        .timer_wake_event_a(wake_a), .timer_wake_event_b(wake_b),
        .timer_wake_event_c(wake_c), .irq_wake(irq_wake),
        .core_clock_en(core_clock_en),
        .peripheral_clock_en(peripheral_clock_en),
        .clock_out_en(clock_out_en),
        .core_from_loop(core_from_loop), .loop_power_on(loop_power_on),
        .core_ratio(core_ratio), .loop_ratio(loop_ratio),
        .mode_state(mode_state));

    strap_source strap_source_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .cfg_sel(cfg_sel),
        .cfg_bypass(cfg_bypass), .cfg_divide(cfg_divide), .pin_o(pin_o),
        .pin_oe(pin_oe), .bypass_pin(bypass_pin),
        .input_divide_pin(input_divide_pin), .general_flag_pin_i(pin_i));

    // ==========================================================
    // Tasks
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
        @(posedge ref_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    // Bounded wait for a mode, then compare it
    task automatic wait_mode(input logic [4:0] m);
        int i;
        for (i = 0; i < 60 && mode_state !== m; i++) begin
            @(posedge ref_clk);
            #1;
        end
        if (mode_state !== m) begin
            err_total++;
            $display("BAD mode_wait expected %h seen %h", m, mode_state);
            give_verdict();
        end else begin
            check("mode", 16'(mode_state), 16'(m));
        end
    endtask

    task automatic count_en();
        n_core = 4'h0;
        n_per = 4'h0;
        n_out = 4'h0;
        repeat (8) begin
            @(posedge ref_clk);
            #1;
            n_core = n_core + 4'(core_clock_en);
            n_per = n_per + 4'(peripheral_clock_en);
            n_out = n_out + 4'(clock_out_en);
        end
    endtask

    task automatic do_reset(input logic b, input logic [6:0] s);
        cfg_bypass = b;
        cfg_sel = s;
        @(posedge ref_clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check("pin_oe_rst", 16'(pin_oe), 16'h0000);
        check("flag_in_rst", 16'(flag_in_data), 16'h0000);
        @(posedge ref_clk);
        rst_n <= 1'b1;
        #1;
        check("mode_rst", 16'(mode_state), 16'h0002);
    endtask

    // ==========================================================
    // Sequence
    initial begin
        do_reset(1'b1, 7'h06);
        rd_reg(CTRL_OFS, val);
        check("ctrl_strap_byp", val, 16'h0300);
        for (int k = 0; k < 5; k++) begin
            wr_reg(CTRL_OFS, {t_sel[k], 1'b1, 7'h00, t_div[k]});
            repeat (4) @(posedge ref_clk);
            #1;
            check("core_ratio", 16'(core_ratio), 16'(t_core[k]));
            check("loop_ratio", 16'(loop_ratio), 16'(t_loop[k]));
        end
        wr_reg(CTRL_OFS, 16'h0c00);
        wait_mode(5'h01);
        @(posedge ref_clk);
        #1;
        check("from_loop", 16'(core_from_loop), 16'h0001);
        check("mult_ratio", 16'(core_ratio), 16'h000c);
        rd_reg(STATUS_OFS, val);
        check("status_mult", val, 16'h8400);
        wr_reg(CTRL_OFS, 16'h1400);
        rd_reg(CTRL_OFS, val);
        check("ctrl_sel_kept", val, 16'h0c00);
        wr_reg(CTRL_OFS, 16'h0c08);
        wait_mode(5'h08);
        count_en();
        check("idle_core", 16'(n_core), 16'h0000);
        check("idle_per", 16'(n_per), 16'h0008);
        check("idle_loop", 16'(loop_power_on), 16'h0001);
        @(posedge ref_clk);
        irq_wake <= 1'b1;
        wait_mode(5'h01);
        irq_wake <= 1'b0;
        rd_reg(CTRL_OFS, val);
        check("ctrl_wake", val, 16'h0c00);
        wr_reg(CTRL_OFS, 16'h0d00);
        wait_mode(5'h02);
        wr_reg(CTRL_OFS, 16'h0d10);
        repeat (3) @(posedge ref_clk);
        count_en();
        check("byp_core", 16'(n_core), 16'h0008);
        check("byp_per", 16'(n_per), 16'h0004);
        wr_reg(CTRL_OFS, 16'h0dd0);
        repeat (3) @(posedge ref_clk);
        count_en();
        check("half_core", 16'(n_core), 16'h0004);
        check("half_per", 16'(n_per), 16'h0002);
        check("clk_out", 16'(n_out), 16'h0002);
        wr_reg(4'h7, 16'hffff);
        rd_reg(4'h7, val);
        check("unmapped", val, 16'h0000);
        rd_reg(CTRL_OFS, val);
        check("ctrl_byp", val, 16'h0dd0);
        wr_reg(CTRL_OFS, 16'h0d32);
        wait_mode(5'h10);
        @(posedge ref_clk);
        irq_wake <= 1'b1;
        count_en();
        check("pdall_core", 16'(n_core), 16'h0000);
        check("pdall_per", 16'(n_per), 16'h0000);
        check("pdall_stay", 16'(mode_state), 16'h0010);
        check("pdall_loop", 16'(loop_power_on), 16'h0000);
        @(posedge ref_clk);
        irq_wake <= 1'b0;
        wake_b <= 1'b1;
        wait_mode(5'h02);
        wake_b <= 1'b0;
        do_reset(1'b0, 7'h06);
        rd_reg(CTRL_OFS, val);
        check("ctrl_strap_sel", val, 16'h0c00);
        @(posedge ref_clk);
        flag_out_oe <= 7'h7f;
        flag_out_data <= 7'h55;
        repeat (6) @(posedge ref_clk);
        #1;
        check("pin_oe_run", 16'(pin_oe), 16'h007f);
        check("pin_o_run", 16'(pin_o), 16'h0055);
        check("flag_in_run", 16'(flag_in_data), 16'h0055);
        wait_mode(5'h01);
        give_verdict();
    end
endmodule
